// File: shared/aac_pkg.sv
package aac_pkg;
   // register indices; the byte address is four times the index
   localparam logic [7:0] IDX_FORMAT = 8'h04;
   localparam logic [7:0] IDX_SYSCTL = 8'h05;
   localparam logic [7:0] IDX_SMUTE = 8'h06;
   localparam logic [7:0] IDX_MVOL = 8'h07;
   localparam logic [7:0] IDX_CH1VOL = 8'h08;
   localparam logic [7:0] IDX_CH2VOL = 8'h09;
   localparam logic [7:0] IDX_CH3VOL = 8'h0A;
   localparam logic [7:0] IDX_CH4VOL = 8'h0B;
   localparam logic [7:0] IDX_HPVOL = 8'h0C;
   localparam logic [7:0] IDX_SUBVOL = 8'h0D;
   localparam logic [7:0] IDX_SDGRP = 8'h19;
   localparam int ADDR_W = 10;
   // reset values
   localparam logic [7:0] RST_FORMAT = 8'h05;
   localparam logic [7:0] RST_SYSCTL = 8'h60;
   localparam logic [7:0] RST_SMUTE = 8'h00;
   localparam logic [7:0] RST_MVOL = 8'hFF;
   localparam logic [7:0] RST_CHVOL = 8'h30;
   localparam logic [7:0] RST_SDGRP = 8'h30;
   // field positions
   localparam int SC_PLAY_BIT = 6;
   localparam int SC_CFG_BIT = 5;
   localparam int SC_VSRC_BIT = 3;
   localparam int SC_MODE_LO = 1;
   localparam int SC_MODE_HI = 2;
   localparam logic [7:0] SC_WMASK = 8'h6E;
   localparam logic [7:0] SM_WMASK = 8'h2F;
   localparam logic [7:0] SD_WMASK = 8'h3F;
   localparam logic [7:0] VOL_MUTE = 8'hFF;
   localparam int NCH = 6;
   typedef enum logic [1:0] {
      AAC_MODE_SPK = 2'b00,
      AAC_MODE_HP = 2'b01,
      AAC_MODE_LINE = 2'b10,
      AAC_MODE_RSVD = 2'b11
   } aac_mode_t;
   typedef enum logic [2:0] {
      AAC_FMT_RJ = 3'b000,
      AAC_FMT_I2S = 3'b001,
      AAC_FMT_LJ = 3'b010,
      AAC_FMT_I2S32 = 3'b011,
      AAC_FMT_LJ32 = 3'b100,
      AAC_FMT_RSVD = 3'b111
   } aac_fmt_t;
   typedef struct packed {
      aac_fmt_t fmt;
      logic [4:0] word_len;
      logic fmt_valid;
   } aac_format_t;
   typedef struct packed {
      logic [NCH-1:0] run;
      logic [NCH-1:0] soft_mute;
      logic hp_active;
      logic headphone_mode;
      logic power_stage_valid;
   } aac_out_t;
endpackage

// File: hw/aac_regs.sv
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
// Operation
// R01: format register defaults to I2S 24-bit
// R02: low five bits encode RJ/I2S/LJ word lengths
// R03: codes 10011/10110 select 32fs I2S/LJ
// R04: play bit one shuts all PWM outputs
// R05: config bit picks all or non-group channels
// R06: software changes config only while shut down
// R07: valid low when shut, high when all run
// R08: volume-source bit selects headphone volume register
// R09: mode field speaker/headphone/line-out with select pin
// R10: forced headphone mode mutes other PWM channels
// R11: software sets volume-source bit for line-out
// R12: soft mute bit gives 50% duty; resets zero
// R13: soft mute bit five is subwoofer channel six
// R14: volume code steps 0.5 dB from +24 dB
// R15: all-ones volume code soft mutes output
// R16: master resets mute, channels reset 0 dB
// R17: shutdown group holds channels off; resets 0x30
// R18: software clears group before all-channel shutdown
// R19: soft mute bits zero to three are channels 1-4
// R20: reserved bits written zero, reserved codes inert
module aac_regs
   import aac_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // pin
   input wire logic headphone_select_pin,
   // to pwm stage
   output aac_out_t pwm_ctl,
   output aac_format_t rx_format,
   output logic [7:0] eff_vol [NCH],
   output logic [7:0] hp_vol_eff
);
   // register storage
   logic [7:0] format_q;
   logic [7:0] sysctl_q;
   logic [7:0] smute_q;
   logic [7:0] mvol_q;
   logic [7:0] hpvol_q;
   logic [7:0] sdgrp_q;
   logic [7:0] chvol_q [NCH];
   // pin synchroniser stages
   logic hp_s1_q;
   logic hp_s2_q;
   logic hp_s3_q;
   logic hp_pin_q;
   // bus decode
   logic acc_ph;
   logic setup_rd;
   logic wr_en;
   logic hit;
   logic [7:0] idx;
   logic [7:0] rdat;
   // write strobes
   logic we_format;
   logic we_sysctl;
   logic we_smute;
   logic we_mvol;
   logic we_hpvol;
   logic we_sdgrp;
   logic [NCH-1:0] we_chvol;
   // control decisions
   aac_mode_t mode;
   logic headphone_mode;
   logic hp_active;
   logic [NCH-1:0] run_ch;
   logic [NCH-1:0] mute_ch;
   aac_format_t fmt_dec;
   // effective volume ahead of the output registers
   logic [7:0] eff_vol_d [NCH];
   logic [7:0] hp_vol_d;

   // apb decode; pready stays high, so no wait states
   assign idx = paddr[ADDR_W-1:2];
   assign acc_ph = psel && penable;
   assign setup_rd = psel && !penable && !pwrite;
   assign wr_en = acc_ph && pwrite && pstrb[0];
   assign pready = 1'h1;
   assign pslverr = acc_ph && !hit; // R20

   // one write strobe per register
   assign we_format = wr_en && (idx == IDX_FORMAT);
   assign we_sysctl = wr_en && (idx == IDX_SYSCTL);
   assign we_smute = wr_en && (idx == IDX_SMUTE);
   assign we_mvol = wr_en && (idx == IDX_MVOL);
   assign we_hpvol = wr_en && (idx == IDX_HPVOL);
   assign we_sdgrp = wr_en && (idx == IDX_SDGRP);
   assign we_chvol[0] = wr_en && (idx == IDX_CH1VOL);
   assign we_chvol[1] = wr_en && (idx == IDX_CH2VOL);
   assign we_chvol[2] = wr_en && (idx == IDX_CH3VOL);
   assign we_chvol[3] = wr_en && (idx == IDX_CH4VOL);
   assign we_chvol[4] = 1'h0;
   assign we_chvol[5] = wr_en && (idx == IDX_SUBVOL);

   // address decode and read mux
   always_comb begin
      hit = 1'h1;
      rdat = 8'h00;
      case (idx)
         IDX_FORMAT: rdat = format_q;
         IDX_SYSCTL: rdat = sysctl_q;
         IDX_SMUTE: rdat = smute_q;
         IDX_MVOL: rdat = mvol_q;
         IDX_CH1VOL: rdat = chvol_q[0];
         IDX_CH2VOL: rdat = chvol_q[1];
         IDX_CH3VOL: rdat = chvol_q[2];
         IDX_CH4VOL: rdat = chvol_q[3];
         IDX_HPVOL: rdat = hpvol_q;
         IDX_SUBVOL: rdat = chvol_q[5];
         IDX_SDGRP: rdat = sdgrp_q;
         default: hit = 1'h0;
      endcase
   end

   // read data loads in the setup cycle and stands through the access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup_rd) begin
         prdata <= {24'h00_0000, rdat};
      end
   end

   // format register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         format_q <= RST_FORMAT; // R01
      end else if (we_format) begin
         format_q <= pwdata[7:0];
      end
   end

   // system control register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sysctl_q <= RST_SYSCTL;
      end else if (we_sysctl) begin
         sysctl_q <= pwdata[7:0] & SC_WMASK; // R20
      end
   end

   // soft mute register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         smute_q <= RST_SMUTE; // R12
      end else if (we_smute) begin
         smute_q <= pwdata[7:0] & SM_WMASK; // R19
      end
   end

   // master volume register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mvol_q <= RST_MVOL; // R16
      end else if (we_mvol) begin
         mvol_q <= pwdata[7:0];
      end
   end

   // headphone volume register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hpvol_q <= RST_CHVOL; // R16
      end else if (we_hpvol) begin
         hpvol_q <= pwdata[7:0];
      end
   end

   // channel volumes; channel five has no register and keeps 0 dB
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NCH; i++) begin
            chvol_q[i] <= RST_CHVOL; // R16
         end
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (we_chvol[i]) begin
               chvol_q[i] <= pwdata[7:0];
            end
         end
      end
   end

   // shutdown group register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sdgrp_q <= RST_SDGRP; // R17
      end else if (we_sdgrp) begin
         sdgrp_q <= pwdata[7:0] & SD_WMASK;
      end
   end

   // headphone select pin synchroniser
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hp_s1_q <= 1'h0;
         hp_s2_q <= 1'h0;
         hp_s3_q <= 1'h0;
         hp_pin_q <= 1'h0;
      end else begin
         hp_s1_q <= headphone_select_pin;
         hp_s2_q <= hp_s1_q;
         hp_s3_q <= hp_s2_q;
         if (hp_s2_q == hp_s3_q) begin
            hp_pin_q <= hp_s3_q;
         end
      end
   end

   // format decode
   always_comb begin
      fmt_dec.fmt = AAC_FMT_RSVD;
      fmt_dec.word_len = 5'h00;
      fmt_dec.fmt_valid = 1'h0;
      if (format_q[7:5] == 3'h0) begin // R02
         fmt_dec.fmt_valid = 1'h1;
         case (format_q[4:0])
            5'h00: begin
               fmt_dec.fmt = AAC_FMT_RJ;
               fmt_dec.word_len = 5'h10;
            end
            5'h01: begin
               fmt_dec.fmt = AAC_FMT_RJ;
               fmt_dec.word_len = 5'h14;
            end
            5'h02: begin
               fmt_dec.fmt = AAC_FMT_RJ;
               fmt_dec.word_len = 5'h18;
            end
            5'h03: begin
               fmt_dec.fmt = AAC_FMT_I2S;
               fmt_dec.word_len = 5'h10;
            end
            5'h04: begin
               fmt_dec.fmt = AAC_FMT_I2S;
               fmt_dec.word_len = 5'h14;
            end
            5'h05: begin
               fmt_dec.fmt = AAC_FMT_I2S;
               fmt_dec.word_len = 5'h18;
            end
            5'h06: begin
               fmt_dec.fmt = AAC_FMT_LJ;
               fmt_dec.word_len = 5'h10;
            end
            5'h07: begin
               fmt_dec.fmt = AAC_FMT_LJ;
               fmt_dec.word_len = 5'h14;
            end
            5'h08: begin
               fmt_dec.fmt = AAC_FMT_LJ;
               fmt_dec.word_len = 5'h18;
            end
            5'h0A: begin
               fmt_dec.fmt = AAC_FMT_RJ;
               fmt_dec.word_len = 5'h12;
            end
            5'h13: begin // R03
               fmt_dec.fmt = AAC_FMT_I2S32;
               fmt_dec.word_len = 5'h10;
            end
            5'h16: begin // R03
               fmt_dec.fmt = AAC_FMT_LJ32;
               fmt_dec.word_len = 5'h10;
            end
            default: fmt_dec.fmt_valid = 1'h0; // R20
         endcase
      end
   end

   // output mode from the mode field and the synchronised pin
   always_comb begin
      mode = aac_mode_t'(sysctl_q[SC_MODE_HI:SC_MODE_LO]);
      headphone_mode = 1'h0;
      hp_active = 1'h0;
      case (mode)
         AAC_MODE_SPK: begin
            headphone_mode = hp_pin_q; // R09
         end
         AAC_MODE_HP: begin
            headphone_mode = 1'h1; // R09
         end
         AAC_MODE_LINE: begin
            hp_active = 1'h1; // R09
         end
         default: begin
            headphone_mode = 1'h0; // R20
         end
      endcase
      if (headphone_mode) begin
         hp_active = 1'h1;
      end
   end

   // channels that switch
   always_comb begin
      if (sysctl_q[SC_PLAY_BIT]) begin
         run_ch = '0; // R04
      end else if (sysctl_q[SC_CFG_BIT]) begin
         run_ch = '1; // R05
      end else begin
         run_ch = ~sdgrp_q[NCH-1:0]; // R05 R17
      end
   end

   // effective volume; master mute overrides every channel code
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         if (mvol_q == VOL_MUTE) begin
            eff_vol_d[i] = VOL_MUTE; // R15
         end else begin
            eff_vol_d[i] = chvol_q[i]; // R14
         end
      end
      if (mvol_q == VOL_MUTE) begin
         hp_vol_d = VOL_MUTE;
      end else if (headphone_mode && !sysctl_q[SC_VSRC_BIT]) begin
         hp_vol_d = hpvol_q; // R08
      end else begin
         hp_vol_d = chvol_q[0]; // R08
      end
   end

   // soft mute per channel
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         mute_ch[i] = smute_q[i] // R12 R19
            | headphone_mode // R10
            | (eff_vol_d[i] == VOL_MUTE); // R15
      end
      // bit four of the soft mute register drives no channel
      mute_ch[4] = headphone_mode | (eff_vol_d[4] == VOL_MUTE); // R13
   end

   // stage control and format outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwm_ctl <= '0;
         rx_format <= '0;
      end else begin
         pwm_ctl.run <= run_ch;
         pwm_ctl.soft_mute <= mute_ch; // R12
         pwm_ctl.hp_active <= hp_active;
         pwm_ctl.headphone_mode <= headphone_mode;
         pwm_ctl.power_stage_valid <= (run_ch == '1); // R07
         rx_format <= fmt_dec;
      end
   end

   // volume outputs, loaded on the same edge as the stage control
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NCH; i++) begin
            eff_vol[i] <= 8'h00;
         end
         hp_vol_eff <= 8'h00;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            eff_vol[i] <= eff_vol_d[i]; // R14
         end
         hp_vol_eff <= hp_vol_d;
      end
   end
endmodule

// File: test/aac_regs_assertions.sv
`timescale 1ns/1ps
module aac_regs_assertions
   import aac_pkg::*;
(
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // pin and stage
   input wire logic headphone_select_pin,
   input wire aac_out_t pwm_ctl,
   input wire aac_format_t rx_format,
   input wire logic [7:0] eff_vol [NCH],
   input wire logic [7:0] hp_vol_eff
);
   wire acc = psel && penable;
   wire [7:0] ix = paddr[9:2];
   wire hit = ix inside {[8'h04:8'h0D], 8'h19};
   wire wr = acc && pwrite && pstrb[0];
   wire wsc = wr && ix == IDX_SYSCTL;
   wire wfm = wr && ix == IDX_FORMAT;
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_err_unmapped: assert property (
      acc && !hit |-> pslverr) else $error("unmapped not refused");
   a_err_mapped: assert property (
      acc && hit |-> !pslverr) else $error("mapped refused");
   a_play_shut: assert property (
      wsc && pwdata[6] |-> ##2 pwm_ctl.run == 6'h00
      && !pwm_ctl.power_stage_valid) else $error("outputs not shut");
   a_all_run: assert property (
      wsc && pwdata[6:5] == 2'h1 |-> ##2 pwm_ctl.run == 6'h3F
      && pwm_ctl.power_stage_valid) else $error("not all run");
   a_vol_mute: assert property (
      (eff_vol[0] == VOL_MUTE) [*2] |-> pwm_ctl.soft_mute[0])
      else $error("mute code not muted");
   a_fmt_rj16: assert property (
      wfm && pwdata[7:0] == 8'h00 |-> ##2 rx_format.fmt == AAC_FMT_RJ
      && rx_format.word_len == 5'h10) else $error("format not rj16");
   a_fmt_rsvd: assert property (
      wfm && pwdata[7:0] == 8'h09 |-> ##2 !rx_format.fmt_valid)
      else $error("reserved format valid");
   a_smute_rd: assert property (
      acc && !pwrite && ix == IDX_SMUTE |-> prdata[31:6] == '0
      && !prdata[4]) else $error("soft mute spare bits set");
   a_hp_mutes: assert property (
      pwm_ctl.headphone_mode |-> pwm_ctl.soft_mute[3:0] == 4'hF)
      else $error("headphone mode left channels unmuted");
   a_valid_run: assert property (
      pwm_ctl.power_stage_valid |-> pwm_ctl.run == 6'h3F)
      else $error("valid high with channels off");
   c_start: cover property (wsc && !pwdata[6]);
   c_err: cover property (acc && pslverr);
   c_hp: cover property (pwm_ctl.headphone_mode);
endmodule

// File: test/aac_regs_tb.sv
`timescale 1ns/1ps
module aac_regs_tb
   import aac_pkg::*;
   ;
   logic pclk = 1'h0;
   logic presetn, psel, penable, pwrite, headphone_select_pin;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic pready, pslverr, er;
   logic [8:0] g;
   aac_out_t pwm_ctl;
   aac_format_t rx_format;
   logic [7:0] eff_vol [NCH];
   logic [7:0] hp_vol_eff;
   int errors, n_compared, cyc;
   // write flag, index, data, read back
   logic [24:0] rows [12] = '{25'h0040005, 25'h0050060, 25'h0060000,
      25'h00700FF, 25'h0080030, 25'h00C0030, 25'h00D0030, 25'h0190030,
      25'h106FF2F, 25'h119FF3F, 25'h1193030, 25'h10AA5A5};
   // code, format kind, word length
   logic [15:0] fm [14] = '{16'h0010, 16'h0114, 16'h0218, 16'h0330,
      16'h0434, 16'h0538, 16'h0650, 16'h0754, 16'h0858, 16'h0A12,
      16'h1370, 16'h1680, 16'h09E0, 16'h11E0};
   wire [6:0] rv = {pwm_ctl.run, pwm_ctl.power_stage_valid};
   aac_regs aac_regs_inst (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
      .headphone_select_pin, .pwm_ctl, .rx_format, .eff_vol, .hp_vol_eff);
   always #10 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         errors++;
         conclude();
      end
   end
   task chk(input string s, input logic [31:0] e, input logic [31:0] v);
      n_compared++;
      if (v !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", s, e, v);
      end
   endtask
   task conclude;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task apb(input logic w, input logic [7:0] ix, input logic [7:0] d);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= {ix, 2'h0};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1) @(posedge pclk);
      er = pslverr;
      rd = prdata;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask
   task set(input logic [7:0] ix, input logic [7:0] d);
      apb(1'h1, ix, d);
      @(posedge pclk);
   endtask
   initial begin
      {presetn, psel, penable, pwrite, headphone_select_pin} = 5'h0;
      paddr = '0;
      pwdata = 32'h0;
      pstrb = 4'h1;
      repeat (20) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      foreach (rows[i]) begin
         if (rows[i][24]) apb(1'h1, rows[i][23:16], rows[i][15:8]);
         apb(1'h0, rows[i][23:16], 8'h00);
         chk("reg", {24'h0, rows[i][7:0]}, rd);
      end
      apb(1'h1, 8'h03, 8'h5A);
      chk("slverr", 32'h1, 32'(er));
      apb(1'h0, 8'h03, 8'h00);
      chk("unmapped", 32'h0, rd);
      foreach (fm[i]) begin
         set(IDX_FORMAT, fm[i][15:8]);
         g = {rx_format.fmt, rx_format.word_len, rx_format.fmt_valid};
         if (fm[i][4:0] == 5'h0) g[5:1] = 5'h0;
         if (fm[i][7:5] == 3'h7) g[8:1] = 8'h0;
         chk("format", 32'(fm[i][7:5] == 3'h7 ? 9'h0 : {fm[i][7:0], 1'h1}),
            32'(g));
      end
      set(IDX_SYSCTL, 8'h60);
      chk("run", 32'h0, 32'(rv));
      set(IDX_SYSCTL, 8'h20);
      chk("run", 32'h7F, 32'(rv));
      set(IDX_SYSCTL, 8'h60);
      set(IDX_SYSCTL, 8'h40);
      set(IDX_SYSCTL, 8'h00);
      chk("run", 32'h0F, 32'(rv[6:1]));
      set(IDX_SDGRP, 8'h00);
      set(IDX_SYSCTL, 8'h40);
      set(IDX_SYSCTL, 8'h60);
      set(IDX_MVOL, 8'h30);
      set(IDX_CH2VOL, 8'hFF);
      set(IDX_HPVOL, 8'h50);
      set(IDX_SMUTE, 8'h21);
      chk("mute", 32'h23, 32'(pwm_ctl.soft_mute));
      chk("vol", 32'hFF30, 32'({eff_vol[1], eff_vol[0]}));
      set(IDX_SYSCTL, 8'h22);
      chk("hp", 32'hA1, 32'({hp_vol_eff, pwm_ctl.headphone_mode}));
      chk("hpmute", 32'hF, 32'(pwm_ctl.soft_mute[3:0]));
      set(IDX_SYSCTL, 8'h2A);
      chk("hp", 32'h61, 32'({hp_vol_eff, pwm_ctl.headphone_mode}));
      set(IDX_SYSCTL, 8'h2C);
      chk("line", 32'h2, 32'({pwm_ctl.hp_active, pwm_ctl.headphone_mode}));
      headphone_select_pin <= 1'h1;
      repeat (8) @(posedge pclk);
      chk("line", 32'h2, 32'({pwm_ctl.hp_active, pwm_ctl.headphone_mode}));
      set(IDX_SYSCTL, 8'h20);
      chk("pin", 32'h1, 32'(pwm_ctl.headphone_mode));
      presetn <= 1'h0;
      headphone_select_pin <= 1'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      apb(1'h0, IDX_SMUTE, 8'h00);
      chk("reset", 32'h0, rd);
      conclude();
   end
endmodule
bind aac_regs aac_regs_assertions aac_regs_assertions_inst (.pclk, .presetn,
   .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
   .pslverr, .headphone_select_pin, .pwm_ctl, .rx_format, .eff_vol,
   .hp_vol_eff);
